// >>> logic/tlap_top.sv
// Torque ceiling selection, command clamp and absolute position word, with an Avalon-MM register slave.
// Assumes commands and encoder samples are synchronous to core_clk_i and arrive as one-cycle valid strobes.
// How it works
// - Forward and reverse internal torque ceilings, 0 to 800, reset 800, apply at once
// - Every ceiling counts in one percent steps of rated torque or force
// - Forward and reverse external ceilings, 0 to 800, reset 100, apply at once
// - Linear motor uses its own internal force ceilings, reset 30
// - Linear motor reuses the external ceiling registers as force ceilings
// - Clamped flag is high exactly while a ceiling limits the output
// - Clamped flag reaches a pin only when the pin mapping selects it
// - Encoder usage 0 multiturn, 1 incremental, 2 single-turn; takes effect on restart
// - Absolute modes report the encoder position directly, no origin return needed
// - Absolute position is multiturn times pulses per rotation plus pulse position
// - Single-turn mode forces the multiturn count to zero
// - Forward external input active selects smaller of internal and external forward
// - Reverse external input active selects smaller of internal and external reverse
// - No ceiling ever exceeds the motor maximum torque
module tlap_top (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic [5:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire tlap_pkg::tlap_cmd_t cmd_i,
    input wire logic fwd_external_limit_input_i,
    input wire logic rev_external_limit_input_i,
    output tlap_pkg::tlap_cmd_t cmd_o,
    output logic torque_clamped_flag_o,
    output logic [tlap_pkg::NUM_PINS-1:0] clamp_pin_o,
    input wire tlap_pkg::tlap_enc_t enc_i,
    output logic [tlap_pkg::POS_W-1:0] abs_pos_o,
    output logic abs_pos_valid_o,
    output logic irq_o
);
    logic [9:0] fwd_int_q, rev_int_q, fwd_ext_q, rev_ext_q, fwd_frc_q, rev_frc_q, max_trq_q;
    logic linear_q;
    logic [1:0] enc_sel_q;
    logic [tlap_pkg::MAP_W-1:0] output_pin_mapping_q;
    logic [23:0] ppr_q;
    tlap_pkg::tlap_enc_mode_t enc_mode_q;
    logic [tlap_pkg::IRQ_W-1:0] irq_sts_q, irq_mask_q, irq_set;
    logic ack_q;
    logic [31:0] rdata_q;
    logic req, wr_go, restart;
    logic [9:0] fwd_int, rev_int, fwd_sel, rev_sel, fwd_ceil, rev_ceil;
    logic signed [15:0] cmd_out_q;
    logic cmd_valid_q, clamped_q, fwd_hit, rev_hit;
    logic [31:0] wmask;
    logic signed [tlap_pkg::POS_W-1:0] raw_pos, base_q, pos_q;
    logic base_ok_q, pos_valid_q;

    // Bus slave: one wait cycle, answer on the second edge
    assign req = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = req & ~ack_q;
    assign wr_go = avs_write_i & ack_q;
    assign restart = wr_go && avs_address_i == tlap_pkg::OFS_RESTART && avs_writedata_i[0] && avs_byteenable_i[0];
    assign avs_readdata_o = rdata_q;
    assign wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}}, {8{avs_byteenable_i[1]}},
                    {8{avs_byteenable_i[0]}}};

    function automatic logic [9:0] ceil_wr(input logic [9:0] old, input logic [31:0] wd, input logic [31:0] m);
        logic [31:0] v;
        v = (32'(old) & ~m) | (wd & m);
        // Writes beyond the settable range saturate at the top of the range
        ceil_wr = (v > 32'(tlap_pkg::CEIL_MAX)) ? tlap_pkg::CEIL_MAX : v[9:0];
    endfunction

    function automatic logic [9:0] min10(input logic [9:0] a, input logic [9:0] b);
        min10 = (a < b) ? a : b;
    endfunction

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            fwd_int_q <= tlap_pkg::RST_INT_TRQ;
            rev_int_q <= tlap_pkg::RST_INT_TRQ;
            fwd_ext_q <= tlap_pkg::RST_EXT;
            rev_ext_q <= tlap_pkg::RST_EXT;
            fwd_frc_q <= tlap_pkg::RST_INT_FRC;
            rev_frc_q <= tlap_pkg::RST_INT_FRC;
            max_trq_q <= tlap_pkg::RST_MAX_TRQ;
            ppr_q <= tlap_pkg::RST_PPR;
            linear_q <= 1'b0;
            enc_sel_q <= 2'h0;
            output_pin_mapping_q <= '0;
            irq_mask_q <= '0;
        end else if (wr_go) begin
            unique case (avs_address_i)
                tlap_pkg::OFS_FWD_INT: fwd_int_q <= ceil_wr(fwd_int_q, avs_writedata_i, wmask);
                tlap_pkg::OFS_REV_INT: rev_int_q <= ceil_wr(rev_int_q, avs_writedata_i, wmask);
                tlap_pkg::OFS_FWD_EXT: fwd_ext_q <= ceil_wr(fwd_ext_q, avs_writedata_i, wmask);
                tlap_pkg::OFS_REV_EXT: rev_ext_q <= ceil_wr(rev_ext_q, avs_writedata_i, wmask);
                tlap_pkg::OFS_FWD_FRC: fwd_frc_q <= ceil_wr(fwd_frc_q, avs_writedata_i, wmask);
                tlap_pkg::OFS_REV_FRC: rev_frc_q <= ceil_wr(rev_frc_q, avs_writedata_i, wmask);
                tlap_pkg::OFS_MAX_TRQ: max_trq_q <= ceil_wr(max_trq_q, avs_writedata_i, wmask);
                tlap_pkg::OFS_PPR: ppr_q <= (ppr_q & ~wmask[23:0]) | (avs_writedata_i[23:0] & wmask[23:0]);
                tlap_pkg::OFS_CONFIG: begin
                    if (avs_byteenable_i[0]) begin
                        linear_q <= avs_writedata_i[tlap_pkg::CFG_LINEAR];
                        enc_sel_q <= avs_writedata_i[tlap_pkg::CFG_ENC_LO +: 2];
                    end
                    if (avs_byteenable_i[1]) begin
                        output_pin_mapping_q <= avs_writedata_i[tlap_pkg::CFG_MAP_LO +: tlap_pkg::MAP_W];
                    end
                end
                tlap_pkg::OFS_IRQ_MASK: begin
                    if (avs_byteenable_i[0]) begin
                        irq_mask_q <= avs_writedata_i[tlap_pkg::IRQ_W-1:0];
                    end
                end
                default: ;
            endcase
        end
    end

    // Encoder usage only changes at restart; the stored selection waits until then
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            enc_mode_q <= tlap_pkg::TLAP_ENC_MULTI;
        end else if (restart) begin
            unique case (enc_sel_q)
                2'h1: enc_mode_q <= tlap_pkg::TLAP_ENC_INCR;
                2'h2: enc_mode_q <= tlap_pkg::TLAP_ENC_SINGLE;
                default: enc_mode_q <= tlap_pkg::TLAP_ENC_MULTI;
            endcase
        end
    end

    // Read data is captured on the first edge of the request, one edge before the answer
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            rdata_q <= '0;
        end else if (avs_read_i & ~ack_q) begin
            unique case (avs_address_i)
                tlap_pkg::OFS_FWD_INT: rdata_q <= 32'(fwd_int_q);
                tlap_pkg::OFS_REV_INT: rdata_q <= 32'(rev_int_q);
                tlap_pkg::OFS_FWD_EXT: rdata_q <= 32'(fwd_ext_q);
                tlap_pkg::OFS_REV_EXT: rdata_q <= 32'(rev_ext_q);
                tlap_pkg::OFS_FWD_FRC: rdata_q <= 32'(fwd_frc_q);
                tlap_pkg::OFS_REV_FRC: rdata_q <= 32'(rev_frc_q);
                tlap_pkg::OFS_MAX_TRQ: rdata_q <= 32'(max_trq_q);
                tlap_pkg::OFS_PPR: rdata_q <= 32'(ppr_q);
                tlap_pkg::OFS_CONFIG: rdata_q <= {21'h0, output_pin_mapping_q, 2'h0, enc_sel_q, 3'h0, linear_q};
                tlap_pkg::OFS_STATUS: rdata_q <= {27'h0, enc_mode_q, rev_hit, fwd_hit, clamped_q};
                tlap_pkg::OFS_IRQ_STS: rdata_q <= 32'(irq_sts_q);
                tlap_pkg::OFS_IRQ_MASK: rdata_q <= 32'(irq_mask_q);
                tlap_pkg::OFS_POS_LO: rdata_q <= pos_q[31:0];
                tlap_pkg::OFS_POS_HI: rdata_q <= {{16{pos_q[47]}}, pos_q[47:32]};
                default: rdata_q <= 32'h0;
            endcase
        end
    end

    // Ceiling selection
    assign fwd_int = linear_q ? fwd_frc_q : fwd_int_q;
    assign rev_int = linear_q ? rev_frc_q : rev_int_q;
    // External registers serve both motor kinds
    assign fwd_sel = fwd_external_limit_input_i ? min10(fwd_int, fwd_ext_q) : fwd_int;
    assign rev_sel = rev_external_limit_input_i ? min10(rev_int, rev_ext_q) : rev_int;
    assign fwd_ceil = min10(fwd_sel, max_trq_q);
    assign rev_ceil = min10(rev_sel, max_trq_q);
    assign fwd_hit = cmd_i.valid && cmd_i.torque > $signed({6'h0, fwd_ceil});
    assign rev_hit = cmd_i.valid && cmd_i.torque < -$signed({6'h0, rev_ceil});

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            cmd_out_q <= '0;
            cmd_valid_q <= 1'b0;
            clamped_q <= 1'b0;
        end else begin
            cmd_valid_q <= cmd_i.valid;
            if (cmd_i.valid) begin
                if (fwd_hit) begin
                    cmd_out_q <= $signed({6'h0, fwd_ceil});
                end else if (rev_hit) begin
                    cmd_out_q <= -$signed({6'h0, rev_ceil});
                end else begin
                    cmd_out_q <= cmd_i.torque;
                end
                // Held between commands so it tracks the torque actually applied
                clamped_q <= fwd_hit | rev_hit;
            end
        end
    end

    assign cmd_o.valid = cmd_valid_q;
    assign cmd_o.torque = cmd_out_q;
    assign torque_clamped_flag_o = clamped_q;

    // Mapping value 0 leaves every pin unused; value k from 1 to 4 drives pin k-1, values 5 to 7 drive no pin
    for (genvar p = 0; p < tlap_pkg::NUM_PINS; p++) begin : g_pin
        assign clamp_pin_o[p] = clamped_q && output_pin_mapping_q == tlap_pkg::MAP_W'(p + 1);
    end

    // Interrupts: set wins over a same-cycle write-one clear
    assign irq_set[tlap_pkg::IRQ_CLAMP_ON] = cmd_i.valid & (fwd_hit | rev_hit) & ~clamped_q;
    assign irq_set[tlap_pkg::IRQ_CLAMP_OFF] = cmd_i.valid & ~(fwd_hit | rev_hit) & clamped_q;

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            irq_sts_q <= '0;
        end else if (wr_go && avs_address_i == tlap_pkg::OFS_IRQ_STS && avs_byteenable_i[0]) begin
            irq_sts_q <= (irq_sts_q & ~avs_writedata_i[tlap_pkg::IRQ_W-1:0]) | irq_set;
        end else begin
            irq_sts_q <= irq_sts_q | irq_set;
        end
    end

    assign irq_o = |(irq_sts_q & irq_mask_q);

    function automatic logic signed [47:0] pos_mul(input logic signed [15:0] mt, input logic [23:0] ppr);
        logic signed [47:0] a, b;
        a = 48'(mt);
        b = $signed({24'h0, ppr});
        pos_mul = 48'(a * b);
    endfunction

    // Absolute position; the product fits in 40 bits of the 48-bit width
    always_comb begin
        raw_pos = (enc_mode_q == tlap_pkg::TLAP_ENC_SINGLE) ?
            $signed({24'h0, enc_i.pulse_pos}) :
            pos_mul(enc_i.multiturn, ppr_q) + $signed({24'h0, enc_i.pulse_pos});
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            base_q <= '0;
            base_ok_q <= 1'b0;
            pos_q <= '0;
            pos_valid_q <= 1'b0;
        end else if (restart) begin
            base_ok_q <= 1'b0;
            pos_q <= '0;
            pos_valid_q <= 1'b0;
        end else if (enc_i.valid) begin
            pos_valid_q <= 1'b1;
            if (enc_mode_q == tlap_pkg::TLAP_ENC_INCR) begin
                // First sample after restart becomes the zero point
                if (!base_ok_q) begin
                    base_q <= raw_pos;
                    base_ok_q <= 1'b1;
                    pos_q <= '0;
                end else begin
                    pos_q <= raw_pos - base_q;
                end
            end else begin
                // Encoder keeps the stop position, so it is reported as is
                pos_q <= raw_pos;
            end
        end
    end

    assign abs_pos_o = pos_q;
    assign abs_pos_valid_o = pos_valid_q;

    sequence clamp_fwd_s;
        cmd_i.valid && fwd_hit;
    endsequence

    sequence out_at_fwd_s;
        cmd_valid_q && cmd_out_q == $signed({6'h0, $past(fwd_ceil)});
    endsequence

    fwd_clamp_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        clamp_fwd_s |=> out_at_fwd_s) else $error("forward clamp value wrong");

    rev_clamp_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        cmd_i.valid && cmd_i.torque < 0 |=> cmd_out_q >= -$signed({6'h0, $past(rev_ceil)}))
        else $error("reverse command exceeds ceiling");

    clamp_flag_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        cmd_i.valid |=> torque_clamped_flag_o == (cmd_out_q != $past(cmd_i.torque)))
        else $error("clamped flag disagrees with output");

    pin_map_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        output_pin_mapping_q == '0 |-> clamp_pin_o == '0) else $error("unmapped pin driven");

    max_torque_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        cmd_i.valid |=> cmd_out_q <= $signed({6'h0, $past(max_trq_q)})
            && cmd_out_q >= -$signed({6'h0, $past(max_trq_q)})) else $error("output above maximum torque");

    fwd_ext_sel_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        !fwd_external_limit_input_i |-> fwd_sel == fwd_int) else $error("forward external applied when off");

    rev_ext_sel_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        rev_external_limit_input_i |-> rev_sel <= rev_ext_q && rev_sel <= rev_int)
        else $error("reverse external not applied");

    single_turn_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        enc_i.valid && !restart && enc_mode_q == tlap_pkg::TLAP_ENC_SINGLE
        |=> abs_pos_o == $signed({24'h0, $past(enc_i.pulse_pos)})) else $error("single-turn count not zero");

    incr_zero_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        restart |=> abs_pos_o == '0 && !abs_pos_valid_o) else $error("incremental start not zero");

    mode_hold_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        !restart |=> $stable(enc_mode_q)) else $error("encoder mode changed without restart");

    bus_answer_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        req && !ack_q |=> !avs_waitrequest_o) else $error("bus answer late");

    bus_idle_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        !req |-> !avs_waitrequest_o) else $error("waitrequest raised while idle");

    sequence incr_first_s;
        enc_i.valid && !restart && enc_mode_q == tlap_pkg::TLAP_ENC_INCR && !base_ok_q;
    endsequence

    incr_first_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        incr_first_s |=> abs_pos_o == '0 && abs_pos_valid_o) else $error("incremental first sample not zero");

    multi_pos_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        enc_i.valid && !restart && enc_mode_q == tlap_pkg::TLAP_ENC_MULTI
        |=> pos_q == 48'($past(enc_i.multiturn)) * $signed({24'h0, $past(ppr_q)})
            + $signed({24'h0, $past(enc_i.pulse_pos)})) else $error("multiturn position wrong");

    pos_valid_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        enc_i.valid && !restart |=> abs_pos_valid_o) else $error("position not reported after sample");

    fwd_ext_on_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        cmd_i.valid && fwd_external_limit_input_i |=> cmd_out_q <= $signed({6'h0, $past(fwd_ext_q)}))
        else $error("forward external ceiling not applied");

    rev_ext_on_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        cmd_i.valid && rev_external_limit_input_i |=> cmd_out_q >= -$signed({6'h0, $past(rev_ext_q)}))
        else $error("reverse external ceiling not applied");

    // A clear in the same cycle as an event must not lose the event
    set_wins_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        irq_set != '0 |=> (irq_sts_q & $past(irq_set)) == $past(irq_set)) else $error("interrupt event lost");
endmodule

// >>> logic/tlap_pkg.sv
// Package for the torque limit and absolute position block.
// Assumes one 100 MHz control clock and a synchronous active-low reset.
package tlap_pkg;
    // Register byte offsets on the Avalon word bus
    localparam logic [5:0] OFS_FWD_INT = 6'h00;
    localparam logic [5:0] OFS_REV_INT = 6'h04;
    localparam logic [5:0] OFS_FWD_EXT = 6'h08;
    localparam logic [5:0] OFS_REV_EXT = 6'h0C;
    localparam logic [5:0] OFS_FWD_FRC = 6'h10;
    localparam logic [5:0] OFS_REV_FRC = 6'h14;
    localparam logic [5:0] OFS_CONFIG = 6'h18;
    localparam logic [5:0] OFS_PPR = 6'h1C;
    localparam logic [5:0] OFS_MAX_TRQ = 6'h20;
    localparam logic [5:0] OFS_STATUS = 6'h24;
    localparam logic [5:0] OFS_IRQ_STS = 6'h28;
    localparam logic [5:0] OFS_IRQ_MASK = 6'h2C;
    localparam logic [5:0] OFS_RESTART = 6'h30;
    localparam logic [5:0] OFS_POS_LO = 6'h34;
    localparam logic [5:0] OFS_POS_HI = 6'h38;
    // Ceilings in 1 % steps of rated torque or force
    localparam int CEIL_W = 10;
    localparam logic [9:0] CEIL_MAX = 10'h320;
    localparam logic [9:0] RST_INT_TRQ = 10'h320;
    localparam logic [9:0] RST_EXT = 10'h064;
    localparam logic [9:0] RST_INT_FRC = 10'h01E;
    localparam logic [9:0] RST_MAX_TRQ = 10'h12C;
    localparam logic [23:0] RST_PPR = 24'h100000;
    // CONFIG field positions
    localparam int CFG_LINEAR = 0;
    localparam int CFG_ENC_LO = 4;
    localparam int CFG_MAP_LO = 8;
    localparam int MAP_W = 3;
    localparam int NUM_PINS = 4;
    // Interrupt status bits
    localparam int IRQ_CLAMP_ON = 0;
    localparam int IRQ_CLAMP_OFF = 1;
    localparam int IRQ_W = 2;
    localparam int POS_W = 48;
    typedef enum logic [1:0] {
        TLAP_ENC_MULTI = 2'h0,
        TLAP_ENC_INCR = 2'h1,
        TLAP_ENC_SINGLE = 2'h2
    } tlap_enc_mode_t;
    typedef struct packed {
        logic valid;
        logic signed [15:0] torque;
    } tlap_cmd_t;
    typedef struct packed {
        logic valid;
        logic signed [15:0] multiturn;
        logic [23:0] pulse_pos;
    } tlap_enc_t;
endpackage

// >>> verif/tlap_partner.sv
// Partner model: the servo torque loop and its rotary encoder, facing the block.
// Assumes callers start each task just after a rising edge of core_clk_i.
module tlap_partner (
    input wire logic core_clk_i,
    output tlap_pkg::tlap_cmd_t cmd_o,
    output tlap_pkg::tlap_enc_t enc_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        cmd_o = '0;
        enc_o = '0;
    end

    // Strobe lasts one cycle; data then scrambles so the block cannot lean on stale lines
    task automatic send_cmd(input logic signed [15:0] t);
        cmd_o <= '{1'b1, t};
        @(posedge core_clk_i);
        cmd_o <= '{1'b0, ~t};
    endtask

    task automatic send_enc(input logic signed [15:0] mt, input logic [23:0] p);
        enc_o <= '{1'b1, mt, p};
        @(posedge core_clk_i);
        enc_o <= '{1'b0, ~mt, ~p};
    endtask
endmodule

// >>> verif/tlap_top_tb.sv
// Self-checking bench for the torque limit and absolute position block.
// Assumes the partner model drives commands and encoder samples; registers go over Avalon-MM.
module tlap_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [5:0] av_addr = '0;
    logic av_rd = 1'b0;
    logic av_wr = 1'b0;
    logic [31:0] av_wdata = '0;
    logic [31:0] av_rdata;
    logic av_wait;
    logic fwd_lim = 1'b0;
    logic rev_lim = 1'b0;
    tlap_pkg::tlap_cmd_t cmd_in;
    tlap_pkg::tlap_cmd_t cmd_out;
    tlap_pkg::tlap_enc_t enc_in;
    logic flag;
    logic [3:0] pins;
    logic [47:0] abs_pos;
    logic abs_vld;
    logic irq;
    int err_count = 0;
    int num_checks = 0;
    int seed = 32'hA15E;
    // Mirror of registers at offsets 0x00 to 0x20, starting from reset values
    int regs[9] = '{800, 800, 100, 100, 30, 30, 0, 32'h00100000, 300};
    int sts = 0;
    int mask = 0;

    initial begin
        forever #5 core_clk_i = ~core_clk_i;
    end

    tlap_partner u_partner (.core_clk_i(core_clk_i), .cmd_o(cmd_in), .enc_o(enc_in));

    tlap_top u_dut (
        .core_clk_i(core_clk_i), .resetn_i(resetn_i), .avs_address_i(av_addr), .avs_read_i(av_rd),
        .avs_write_i(av_wr), .avs_writedata_i(av_wdata), .avs_byteenable_i(4'hF), .avs_readdata_o(av_rdata),
        .avs_waitrequest_o(av_wait), .cmd_i(cmd_in), .fwd_external_limit_input_i(fwd_lim),
        .rev_external_limit_input_i(rev_lim), .cmd_o(cmd_out), .torque_clamped_flag_o(flag),
        .clamp_pin_o(pins), .enc_i(enc_in), .abs_pos_o(abs_pos), .abs_pos_valid_o(abs_vld), .irq_o(irq)
    );

    task automatic report_and_stop();
        if (err_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // Request held until waitrequest is seen low at a rising edge; released only then
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        av_addr <= a;
        av_wdata <= d;
        av_wr <= wr;
        av_rd <= ~wr;
        @(posedge core_clk_i);
        while (av_wait !== 1'b0) begin
            n++;
            if (n > 20) begin
                err_count++;
                report_and_stop();
            end
            @(posedge core_clk_i);
        end
        q = av_rdata;
        av_wr <= 1'b0;
        av_rd <= 1'b0;
        @(posedge core_clk_i);
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [5:0] a, output logic [31:0] q);
        bus(1'b0, a, 32'h00000000, q);
    endtask

    function automatic int rnd(input int n);
        return $unsigned($random(seed)) % n;
    endfunction

    // Ceiling: internal, or the smaller of internal and external while the input is on, capped at motor max
    function automatic int lim(input int i, input int x, input int on);
        int c;
        c = (on != 0 && x < i) ? x : i;
        return (c > regs[8]) ? regs[8] : c;
    endfunction

    initial begin
        logic [31:0] q;
        logic pf;
        longint e;
        longint b0;
        int idx, v, lin, fl, rl, fc, rc, t, et, m, mode, mt, pos;
        logic ef;
        pf = 1'b0;
        b0 = 0;
        e = 0;
        repeat (10) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        @(posedge core_clk_i);
        chk({cmd_out, flag, pins, irq, abs_vld}, 64'h0);
        chk(abs_pos, 64'h0);
        for (int i = 0; i < 16; i++) begin
            if (i != 12) begin
                rd(6'(i * 4), q);
                chk(q, (i < 9) ? regs[i] : 0);
            end
        end
        wr(6'h3C, 32'h0000FFFF);
        rd(6'h3C, q);
        chk(q, 64'h0);
        for (int i = 0; i < 6; i++) begin
            wr(6'(i * 4), 32'h000003FF);
            rd(6'(i * 4), q);
            chk(q, 64'h320);
            regs[i] = 800;
        end
        for (int n = 0; n < 300; n++) begin
            idx = rnd(9);
            v = (idx == 6) ? ((rnd(5) << 8) | rnd(2)) : rnd(801);
            wr(6'(idx * 4), 32'(v));
            regs[idx] = v;
            v = rnd(4);
            wr(tlap_pkg::OFS_IRQ_STS, 32'(v));
            sts = sts & ~v;
            mask = rnd(4);
            wr(tlap_pkg::OFS_IRQ_MASK, 32'(mask));
            lin = regs[6] & 1;
            fl = rnd(2);
            rl = rnd(2);
            fwd_lim <= 1'(fl);
            rev_lim <= 1'(rl);
            t = rnd(2001) - 1000;
            u_partner.send_cmd(16'(t));
            #1;
            fc = lim(regs[lin ? 4 : 0], regs[2], fl);
            rc = lim(regs[lin ? 5 : 1], regs[3], rl);
            et = (t > fc) ? fc : ((t < -rc) ? -rc : t);
            ef = (t > fc) || (t < -rc);
            if (ef && !pf) sts = sts | 1;
            if (!ef && pf) sts = sts | 2;
            pf = ef;
            m = (regs[6] >> 8) & 7;
            chk(cmd_out.valid, 64'h1);
            chk(cmd_out.torque, 16'(et));
            chk(flag, ef);
            chk(pins, (m > 0) ? (ef << (m - 1)) : 0);
            chk(irq, (sts & mask) != 0);
            @(posedge core_clk_i);
            rd(tlap_pkg::OFS_IRQ_STS, q);
            chk(q, sts);
        end
        wr(tlap_pkg::OFS_PPR, 32'h000003E8);
        for (int k = 0; k < 3; k++) begin
            mode = (k + 1) % 3;
            wr(tlap_pkg::OFS_CONFIG, 32'(mode << 4));
            rd(tlap_pkg::OFS_STATUS, q);
            chk(q[4:3], (mode + 2) % 3);
            wr(tlap_pkg::OFS_RESTART, 32'h00000001);
            rd(tlap_pkg::OFS_STATUS, q);
            chk(q[4:3], mode);
            chk(abs_pos, 64'h0);
            for (int s = 0; s < 4; s++) begin
                mt = rnd(65536) - 32768;
                pos = rnd(1000);
                u_partner.send_enc(16'(mt), 24'(pos));
                #1;
                e = (mode == 2) ? longint'(pos) : longint'(mt) * 1000 + pos;
                if (mode == 1 && s == 0) b0 = e;
                if (mode == 1) e = e - b0;
                chk(abs_pos, e[47:0]);
                chk(abs_vld, 64'h1);
                @(posedge core_clk_i);
            end
            rd(tlap_pkg::OFS_POS_LO, q);
            chk(q, e[31:0]);
            rd(tlap_pkg::OFS_POS_HI, q);
            chk(q, {{16{e[47]}}, e[47:32]});
        end
        report_and_stop();
    end
endmodule
